// [rtl/emergency_halt_direction_control.sv]
// Emergency halt sequencer with direction inversion and register port
`timescale 1ns/100ps
`default_nettype none
module emergency_halt_direction_control (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Register port
  input wire logic [halt_pkg::AW-1:0] i_addr,
  input wire logic [halt_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [halt_pkg::DW-1:0] o_rdata,
  // Switch and operator pins, asynchronous
  input wire logic i_halt_n,
  input wire logic i_pos_limit,
  input wire logic i_neg_limit,
  input wire logic i_ref_switch,
  input wire logic i_fault_ack,
  input wire logic i_op_halt,
  input wire logic i_op_confirm,
  input wire logic i_dc_overvolt,
  // Motion logic, same clock
  input wire logic i_soft_pos_zone,
  input wire logic i_soft_neg_zone,
  input wire logic i_ref_watch,
  input wire logic i_malfunction,
  input wire logic i_fault_cat1,
  input wire logic i_gear_mode,
  input wire logic [halt_pkg::DW-1:0] i_gear_max_accel,
  input wire logic [halt_pkg::DW-1:0] i_normal_decel,
  input wire logic i_move_cmd,
  input wire logic i_cmd_dir_neg,
  input wire logic [halt_pkg::DW-1:0] i_cmd_speed,
  input wire logic i_motor_still,
  // Profile generator and drive outputs
  output logic [halt_pkg::DW-1:0] o_target_speed,
  output logic o_dir_out,
  output logic o_power_en,
  output logic o_halt_active,
  output logic [7:0] o_error_code,
  output logic o_cmd_reject,
  output logic o_irq
);
  import halt_pkg::*;

  // Address match, shared by write and read decode
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    return a == ofs;
  endfunction : hit

  logic rst_meta_r;   // Reset release, first stage
  logic rst_sync_r;   // Reset used by the rest of the design
  // Assert at once, release through two flops to avoid recovery hazards
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  logic [NPIN-1:0] pins_async;  // Raw pins
  logic [NPIN-1:0] pins_s;      // Synchronised pins
  logic [NPIN-1:0] pins_d_r;    // Previous synchronised value
  logic [NPIN-1:0] rise;        // Rising edges
  assign pins_async = {i_dc_overvolt, i_op_confirm, i_op_halt, i_fault_ack,
                       i_ref_switch, i_neg_limit, i_pos_limit, i_halt_n};
  pin_sync #(.W(NPIN), .RST_VAL(PIN_RST)) u_sync (
    .i_clk(i_mclk),
    .i_rst_n(rst_sync_r),
    .i_ce(i_ce),
    .i_async(pins_async),
    .o_sync(pins_s)
  );
  // Edge detection works on synchronised copies only
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      pins_d_r <= PIN_RST;
    else if (i_ce)
      pins_d_r <= pins_s;
  end
  assign rise = pins_s & ~pins_d_r;

  // Register file
  logic ctrl_en_r;                // Power stage enable request
  logic sw_halt_r;                // Software halt pulse
  logic [15:0] inv_r;             // Rotation invert setting
  logic [15:0] mask_r;            // Emergency ramp select mask
  logic [DW-1:0] decel_r;         // Emergency deceleration rate
  logic [IRQ_W-1:0] irq_stat_r;   // Sticky events
  logic [IRQ_W-1:0] irq_mask_r;   // Interrupt enables
  logic wr_ctrl;
  assign wr_ctrl = i_wr && hit(i_addr, OFS_CTRL);
  // Settings; inversion touches nothing else, other values stay in force
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      ctrl_en_r <= 1'b0;
      inv_r <= RST_INVERT;
      mask_r <= RST_MASK;
      decel_r <= RST_DECEL;
    end
    else if (i_ce && i_wr)
    begin
      if (hit(i_addr, OFS_CTRL))
        ctrl_en_r <= i_wdata[CTRL_PWR];
      if (hit(i_addr, OFS_INVERT))
        inv_r <= i_wdata[15:0];
      if (hit(i_addr, OFS_MASK))
        mask_r <= i_wdata[15:0];
      if (hit(i_addr, OFS_DECEL))
        decel_r <= i_wdata;
    end
  end
  // Software halt lives one cycle after its write
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      sw_halt_r <= 1'b0;
    else if (i_ce)
      sw_halt_r <= wr_ctrl && i_wdata[CTRL_SWHALT];
  end

  // Ramp link
  ramp_if rp ();
  decel_ramp u_ramp (
    .i_clk(i_mclk),
    .i_rst_n(rst_sync_r),
    .i_ce(i_ce),
    .rp(rp.ramp)
  );

  // Sequencer state
  halt_state_t state_r;       // Idle, braking, or held awaiting acknowledge
  logic [7:0] cause_r;        // Sources seen during this halt
  logic mal_r;                // Malfunction among the causes
  logic cat1_r;               // Malfunction is category one
  logic ovt_r;                // Overvoltage trip, error pending
  logic cmd_dir_r;            // Commanded direction, one is negative
  logic [DW-1:0] cmd_speed_r; // Commanded speed
  logic moving;
  logic standstill;
  logic pos_trip;
  logic neg_trip;
  logic [7:0] src;            // Live halt sources
  logic trigger;
  logic ack_ev;
  logic ack_ok;
  logic emer;                 // Emergency ramp selected
  logic [IRQ_W-1:0] ev;       // Event pulses

  assign moving = !rp.still;
  // Profile at zero and motor confirmed still; covers the coasting case
  assign standstill = rp.still && i_motor_still;
  // Limits guard the physical sense; inverted, positive switch sees negative moves
  assign pos_trip = pins_s[PIN_POS] && moving && (cmd_dir_r == inv_r[0]);
  assign neg_trip = pins_s[PIN_NEG] && moving && (cmd_dir_r != inv_r[0]);

  // Gather the halt sources in mask bit order
  always_comb
  begin
    src = '0;
    src[MSK_POS] = pos_trip || i_soft_pos_zone;
    src[MSK_NEG] = neg_trip || i_soft_neg_zone;
    src[MSK_HALT] = !pins_s[PIN_HALT_N];
    src[MSK_REF] = pins_s[PIN_REF] && i_ref_watch;
    src[MSK_SW] = sw_halt_r || rise[PIN_OPHALT];
  end
  assign trigger = (|src) || i_malfunction;
  // Only edges count; a held level never acknowledges
  assign ack_ev = rise[PIN_ACK] || rise[PIN_CONFIRM];
  // Halt input and overvoltage must be gone first
  assign ack_ok = ack_ev && !src[MSK_HALT] && !pins_s[PIN_OVT];

  // Halt sequencer
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      state_r <= ST_IDLE;
    else if (i_ce)
    begin
      case (state_r)
        ST_IDLE:
          if (trigger)
            state_r <= ST_BRAKE;
        ST_BRAKE:
          if (standstill)
            state_r <= ST_HELD;     // no way out while moving
        ST_HELD:
          if (ack_ok)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Causes accumulate until the halt is held, then stay frozen until acknowledged, so status shows them
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      cause_r <= '0;
      mal_r <= 1'b0;
      cat1_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (state_r == ST_HELD && ack_ok)
      begin
        cause_r <= '0;
        mal_r <= 1'b0;
        cat1_r <= 1'b0;
      end
      else if (state_r != ST_HELD)
      begin
        cause_r <= cause_r | src;
        mal_r <= mal_r || i_malfunction;
        cat1_r <= cat1_r || (i_malfunction && i_fault_cat1);
      end
    end
  end

  // Overvoltage while halting trips the stage until acknowledged
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      ovt_r <= 1'b0;
    else if (i_ce)
    begin
      if (state_r != ST_IDLE && pins_s[PIN_OVT])
        ovt_r <= 1'b1;
      else if (state_r == ST_HELD && ack_ok)
        ovt_r <= 1'b0;
    end
  end

  // Command latch; a halt cancels the move so it does not resume later
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      cmd_speed_r <= '0;
      cmd_dir_r <= 1'b0;
    end
    else if (i_ce && state_r == ST_IDLE)
    begin
      if (trigger)
        cmd_speed_r <= '0;
      else if (i_move_cmd)
      begin
        cmd_speed_r <= i_cmd_speed;
        cmd_dir_r <= i_cmd_dir_neg;
      end
    end
  end

  // Ramp control; gear mode overrides the mask entirely
  assign emer = (|(cause_r & mask_r[7:0])) || mal_r;
  assign rp.load = (state_r == ST_IDLE) && !trigger;
  assign rp.speed_in = cmd_speed_r;
  assign rp.brake = (state_r == ST_BRAKE);
  assign rp.rate = i_gear_mode ? i_gear_max_accel :
                   (emer ? decel_r : i_normal_decel);

  // Events for the interrupt status
  assign ev[IRQ_START] = (state_r == ST_IDLE) && trigger;
  assign ev[IRQ_STILL] = (state_r == ST_BRAKE) && standstill;
  assign ev[IRQ_OVT] = (state_r != ST_IDLE) && pins_s[PIN_OVT] && !ovt_r;
  assign ev[IRQ_REJ] = i_move_cmd && (state_r != ST_IDLE);

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end
    else if (i_ce)
    begin
      if (i_wr && hit(i_addr, OFS_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~i_wdata[IRQ_W-1:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      if (i_wr && hit(i_addr, OFS_IRQ_MASK))
        irq_mask_r <= i_wdata[IRQ_W-1:0];
    end
  end

  // Drive outputs, all registered
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_target_speed <= '0;
      o_dir_out <= 1'b0;
      o_power_en <= 1'b0;
      o_halt_active <= 1'b0;
      o_error_code <= ERR_NONE;
      o_cmd_reject <= 1'b0;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      // Held halt forces zero; braking follows the ramp
      case (state_r)
        ST_IDLE:
          o_target_speed <= cmd_speed_r;
        ST_BRAKE:
          o_target_speed <= rp.speed;
        default:
          o_target_speed <= '0;
      endcase
      o_dir_out <= cmd_dir_r ^ inv_r[0];
      // Category one keeps the stage on; other malfunctions drop it at rest
      o_power_en <= ctrl_en_r && !ovt_r &&
                    !(state_r == ST_HELD && mal_r && !cat1_r);
      o_halt_active <= (state_r != ST_IDLE);
      o_error_code <= ovt_r ? ERR_OVERVOLT : ERR_NONE;
      o_cmd_reject <= i_move_cmd && (state_r != ST_IDLE || trigger);
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  logic [DW-1:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = '0;
    if (hit(i_addr, OFS_CTRL))
      rdata_nxt[CTRL_PWR] = ctrl_en_r;
    else if (hit(i_addr, OFS_INVERT))
      rdata_nxt[15:0] = inv_r;
    else if (hit(i_addr, OFS_MASK))
      rdata_nxt[15:0] = mask_r;
    else if (hit(i_addr, OFS_DECEL))
      rdata_nxt = decel_r;
    else if (hit(i_addr, OFS_STATUS))
      rdata_nxt = {8'h00, o_error_code, 3'h0, o_power_en, ovt_r,
                   (state_r == ST_HELD), (state_r != ST_IDLE), mal_r, cause_r};
    else if (hit(i_addr, OFS_IRQ_STAT))
      rdata_nxt[IRQ_W-1:0] = irq_stat_r;
    else if (hit(i_addr, OFS_IRQ_MASK))
      rdata_nxt[IRQ_W-1:0] = irq_mask_r;
  end
  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      o_rdata <= '0;
    else if (i_ce)
      o_rdata <= i_rd ? rdata_nxt : '0;
  end

  // Checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_sync_r);

  chk_source_starts_halt: assert property (
    (i_ce && state_r == ST_IDLE && trigger) |=> (state_r == ST_BRAKE) ##1 o_halt_active)
    else $error("halt source did not start braking");
  chk_brake_until_still: assert property (
    (state_r == ST_BRAKE && !standstill) |=> (state_r != ST_IDLE))
    else $error("halt left before standstill");
  chk_cat1_power_on: assert property (
    (i_ce && state_r == ST_HELD && cat1_r && ctrl_en_r && !ovt_r) |=> o_power_en)
    else $error("category one halt dropped power");
  chk_gear_rate_used: assert property (
    (state_r == ST_BRAKE && i_gear_mode) |-> (rp.rate == i_gear_max_accel))
    else $error("gear mode not braking at gear rate");
  chk_mask_normal_ramp: assert property (
    (state_r == ST_BRAKE && !i_gear_mode && !mal_r && (cause_r & mask_r[7:0]) == 8'h00)
    |-> (rp.rate == i_normal_decel))
    else $error("unmasked source used emergency ramp");
  chk_overvolt_trip: assert property (
    (i_ce && ovt_r) |=> (!o_power_en && o_error_code == ERR_OVERVOLT))
    else $error("overvoltage did not trip the stage");
  chk_ack_level_idle: assert property (
    (i_ce && state_r == ST_HELD && !ack_ev) |=> (state_r == ST_HELD))
    else $error("held halt left without an edge");
  chk_invert_dir_out: assert property (
    i_ce |=> (o_dir_out == ($past(cmd_dir_r) ^ $past(inv_r[0]))))
    else $error("direction output not inverted per setting");
  chk_inverted_limit: assert property (
    (i_ce && state_r == ST_IDLE && moving && pins_s[PIN_POS] && cmd_dir_r && inv_r[0])
    |=> (state_r == ST_BRAKE))
    else $error("inverted positive limit ignored negative motion");
  chk_reject_in_halt: assert property (
    (i_ce && i_move_cmd && state_r == ST_HELD) |=> (o_cmd_reject && o_target_speed == '0))
    else $error("command not rejected during held halt");

  cov_pin_halt: cover property ((state_r == ST_IDLE && src[MSK_HALT]) ##1 (state_r == ST_BRAKE));
  cov_reach_held: cover property ((state_r == ST_BRAKE) ##1 (state_r == ST_HELD));
  cov_ack_release: cover property ((state_r == ST_HELD && ack_ok && i_ce) ##1 (state_r == ST_IDLE));
  cov_overvolt: cover property (ovt_r && state_r == ST_BRAKE);
endmodule : emergency_halt_direction_control
`default_nettype wire

// [rtl/halt_pkg.sv]
// Constants, types and register map of the emergency halt controller
package halt_pkg;
  localparam int DW = 32;                        // Register and speed width
  localparam int AW = 5;                         // Register address width
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 5'h00;
  localparam logic [AW-1:0] OFS_INVERT = 5'h04;
  localparam logic [AW-1:0] OFS_MASK = 5'h08;
  localparam logic [AW-1:0] OFS_DECEL = 5'h0c;
  localparam logic [AW-1:0] OFS_STATUS = 5'h10;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 5'h18;
  // Control register fields
  localparam int CTRL_PWR = 0;                   // Power stage enable request
  localparam int CTRL_SWHALT = 1;                // Software halt command, write one
  // Values after reset
  localparam logic [15:0] RST_INVERT = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [DW-1:0] RST_DECEL = 32'h0000_1770;
  // Halt source bits, shared by cause and ramp mask
  localparam int MSK_POS = 0;
  localparam int MSK_NEG = 1;
  localparam int MSK_HALT = 2;
  localparam int MSK_REF = 3;
  localparam int MSK_SW = 7;
  // Synchronised pin positions
  localparam int NPIN = 8;
  localparam int PIN_HALT_N = 0;
  localparam int PIN_POS = 1;
  localparam int PIN_NEG = 2;
  localparam int PIN_REF = 3;
  localparam int PIN_ACK = 4;
  localparam int PIN_OPHALT = 5;
  localparam int PIN_CONFIRM = 6;
  localparam int PIN_OVT = 7;
  localparam logic [NPIN-1:0] PIN_RST = 8'h01;  // Halt input idles high
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_OVERVOLT = 8'h05;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_START = 0;
  localparam int IRQ_STILL = 1;
  localparam int IRQ_OVT = 2;
  localparam int IRQ_REJ = 3;
  // Halt sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_BRAKE, ST_HELD} halt_state_t;
endpackage : halt_pkg

// [rtl/ramp_if.sv]
// Link between the halt sequencer and its deceleration ramp
`timescale 1ns/100ps
`default_nettype none
interface ramp_if;
  logic load;                       // Track commanded speed
  logic [halt_pkg::DW-1:0] speed_in;  // Commanded speed
  logic brake;                      // Decelerate this cycle
  logic [halt_pkg::DW-1:0] rate;      // Speed step per cycle
  logic [halt_pkg::DW-1:0] speed;     // Ramp speed
  logic still;                      // Ramp at zero
  modport ctrl (output load, speed_in, brake, rate, input speed, still);
  modport ramp (input load, speed_in, brake, rate, output speed, still);
endinterface : ramp_if
`default_nettype wire

// [rtl/pin_sync.sv]
// Two flip-flop synchronisers for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Pins in, synchronised copies out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_r;  // First stage, read only by the second
      // Reset values match the idle level so nothing trips at start
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_r <= RST_VAL[g];
          o_sync[g] <= RST_VAL[g];
        end
        else if (i_ce)
        begin
          meta_r <= i_async[g];
          o_sync[g] <= meta_r;
        end
      end
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

// [rtl/decel_ramp.sv]
// Speed ramp that tracks the command and brakes at a given rate
`timescale 1ns/100ps
`default_nettype none
module decel_ramp (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Sequencer side
  ramp_if.ramp rp
);
  import halt_pkg::*;
  logic [DW-1:0] speed_r;  // Present ramp speed
  // Subtract the rate each cycle and clamp, so no wrap past zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      speed_r <= '0;
    else if (i_ce)
    begin
      if (rp.load)
        speed_r <= rp.speed_in;
      else if (rp.brake)
        speed_r <= (speed_r > rp.rate) ? speed_r - rp.rate : '0;
    end
  end
  assign rp.speed = speed_r;
  assign rp.still = (speed_r == '0);
endmodule : decel_ramp
`default_nettype wire

// [bench/switch_model.sv]
// Switches, halt pin and operator panel in front of the controller
`timescale 1ns/100ps
`default_nettype none
module switch_model (
  // Clock
  input wire logic i_clk,
  // Bench requests
  input wire logic i_halt_req,
  input wire logic i_ack_req,
  input wire logic i_via_panel,
  input wire logic i_op_stop,
  input wire logic i_pos_hit,
  // Pins towards the controller
  output logic o_halt_n,
  output logic o_pos_limit,
  output logic o_fault_ack,
  output logic o_op_halt,
  output logic o_op_confirm
);
  // Idle pins at time zero, halt pin idles high
  initial
  begin
    o_halt_n = 1'b1;
    o_pos_limit = 1'b0;
    o_fault_ack = 1'b0;
    o_op_halt = 1'b0;
    o_op_confirm = 1'b0;
  end
  // Contacts follow the bench; acknowledge waits for a released halt pin
  always @(posedge i_clk)
  begin
    o_halt_n <= !i_halt_req;
    o_pos_limit <= i_pos_hit;
    o_op_halt <= i_op_stop;
    o_fault_ack <= i_ack_req & !i_via_panel & o_halt_n;
    o_op_confirm <= i_ack_req & i_via_panel & o_halt_n;
  end
endmodule : switch_model
`default_nettype wire

// [bench/tb_emergency_halt_direction_control.sv]
// Self-checking bench for the emergency halt controller
`timescale 1ns/100ps
`default_nettype none
module tb_emergency_halt_direction_control;
  import halt_pkg::*;
  // Clock, reset and register port
  logic mclk, rstn, wr, rd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, rv, cspd, ndec, gacc, tspd;
  // Model requests and pins
  logic halt_req, ack_req, panel, op_stop, pos_hit;
  logic halt_n, pos_lim, f_ack, op_halt, op_conf;
  // Motion side inputs and controller outputs
  logic ovt, soft_p, soft_n, ref_sw, ref_w, malf, cat1, gear, move, dneg, still;
  logic [7:0] err;
  logic dir, pwr, hact, rej, irq, seen;
  int failures, samples_checked, cycles;

  switch_model model (.i_clk(mclk), .i_halt_req(halt_req), .i_ack_req(ack_req), .i_via_panel(panel),
    .i_op_stop(op_stop), .i_pos_hit(pos_hit), .o_halt_n(halt_n), .o_pos_limit(pos_lim),
    .o_fault_ack(f_ack), .o_op_halt(op_halt), .o_op_confirm(op_conf));
  emergency_halt_direction_control dut (.i_mclk(mclk), .i_rstn(rstn), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_halt_n(halt_n), .i_pos_limit(pos_lim),
    .i_neg_limit(1'b0), .i_ref_switch(ref_sw), .i_fault_ack(f_ack), .i_op_halt(op_halt),
    .i_op_confirm(op_conf), .i_dc_overvolt(ovt), .i_soft_pos_zone(soft_p), .i_soft_neg_zone(soft_n),
    .i_ref_watch(ref_w), .i_malfunction(malf), .i_fault_cat1(cat1), .i_gear_mode(gear),
    .i_gear_max_accel(gacc), .i_normal_decel(ndec), .i_move_cmd(move), .i_cmd_dir_neg(dneg),
    .i_cmd_speed(cspd), .i_motor_still(still), .o_target_speed(tspd), .o_dir_out(dir),
    .o_power_en(pwr), .o_halt_active(hact), .o_error_code(err), .o_cmd_reject(rej), .o_irq(irq));

  // Verdict, reached from the main flow or the hang guard
  task end_of_test();
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // One comparison, four-state exact
  task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Register write and read, one strobe cycle each
  task wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [AW-1:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg
  // Bounded wait for the halt flag; the caller judges it
  task wait_halt(input logic want);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      #1;
      if (hact === want) break;
    end
  endtask : wait_halt
  // Release the halt pin, then acknowledge with a clean rising edge
  task ack(input logic p);
    halt_req <= 1'b0;
    cyc(4);
    panel <= p;
    ack_req <= 1'b1;
    cyc(4);
    ack_req <= 1'b0;
  endtask : ack
  // One move command pulse; a refusal shows within three cycles
  task cmd(input logic neg);
    @(posedge mclk);
    move <= 1'b1;
    dneg <= neg;
    @(posedge mclk);
    move <= 1'b0;
    seen = 1'b0;
    repeat (3)
    begin
      #1 seen |= rej;
      @(posedge mclk);
    end
  endtask : cmd

  // Reset values, unmapped address, power on
  task t_regs();
    rd_reg(OFS_INVERT);
    chk(rv, {16'h0000, RST_INVERT});
    rd_reg(OFS_MASK);
    chk(rv, {16'h0000, RST_MASK});
    rd_reg(5'h1c);
    chk(rv, 32'h0000_0000);
    wr_reg(OFS_CTRL, 32'h0000_0001);
  endtask : t_regs
  // Pin halt holds while moving, refuses commands, clears on acknowledge
  task t_halt_pin();
    still <= 1'b0;
    wr_reg(OFS_MASK, 32'h0000_0004);
    halt_req <= 1'b1;
    wait_halt(1'b1);
    chk(hact, 1'b1);
    ack(1'b0);
    cyc(10);
    chk(hact, 1'b1);
    still <= 1'b1;
    cyc(6);
    chk(tspd, 32'h0000_0000);
    cmd(1'b0);
    chk(seen, 1'b1);
    ack(1'b0);
    wait_halt(1'b0);
    chk(hact, 1'b0);
  endtask : t_halt_pin
  // A steady acknowledge level must not clear an operator halt
  task t_level_ack();
    ack_req <= 1'b1;
    cyc(4);
    op_stop <= 1'b1;
    cyc(2);
    op_stop <= 1'b0;
    wait_halt(1'b1);
    chk(hact, 1'b1);
    cyc(15);
    chk(hact, 1'b1);
    ack_req <= 1'b0;
    cyc(3);
    ack(1'b1);
    wait_halt(1'b0);
    chk(hact, 1'b0);
  endtask : t_level_ack
  // Malfunction: power kept at standstill only for category one
  task t_malf(input logic c);
    malf <= 1'b1;
    cat1 <= c;
    cyc(1);
    malf <= 1'b0;
    wait_halt(1'b1);
    chk(hact, 1'b1);
    cyc(8);
    chk(pwr, c);
    ack(1'b0);
    wait_halt(1'b0);
  endtask : t_malf
  // Overvoltage while braking: power off, error five, interrupt
  task t_overvolt();
    still <= 1'b0;
    halt_req <= 1'b1;
    wait_halt(1'b1);
    ovt <= 1'b1;
    wr_reg(OFS_IRQ_MASK, 32'h0000_0004);
    cyc(6);
    chk(err, ERR_OVERVOLT);
    chk(pwr, 1'b0);
    chk(irq, 1'b1);
    ovt <= 1'b0;
    cyc(4);
    wr_reg(OFS_IRQ_STAT, 32'h0000_000f);
    cyc(2);
    chk(irq, 1'b0);
    still <= 1'b1;
    ack(1'b0);
    wait_halt(1'b0);
    chk(hact, 1'b0);
    wr_reg(OFS_IRQ_MASK, 32'h0000_0000);
  endtask : t_overvolt
  // Inverted sense: positive switch guards negative motion only
  task t_invert();
    wr_reg(OFS_INVERT, 32'h0000_0001);
    cmd(1'b0);
    chk(dir, 1'b1);
    pos_hit <= 1'b1;
    cyc(8);
    chk(hact, 1'b0);
    pos_hit <= 1'b0;
    cyc(3);
    cmd(1'b1);
    pos_hit <= 1'b1;
    wait_halt(1'b1);
    chk(hact, 1'b1);
    rd_reg(OFS_MASK);
    chk(rv, 32'h0000_0004);
    rd_reg(OFS_DECEL);
    chk(rv, RST_DECEL);
    pos_hit <= 1'b0;
    cyc(20);
    ack(1'b0);
    wait_halt(1'b0);
    chk(hact, 1'b0);
  endtask : t_invert
  // Soft zone halt: first braked step shows which rate was chosen
  task t_ramp(input logic g, input logic [DW-1:0] exp);
    gear <= g;
    cmd(1'b0);
    soft_p <= 1'b1;
    wait_halt(1'b1);
    @(posedge mclk);
    #1 chk(tspd, exp);
    soft_p <= 1'b0;
    cyc(12);
    ack(1'b0);
    wait_halt(1'b0);
    chk(hact, 1'b0);
    gear <= 1'b0;
  endtask : t_ramp

  // 10 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard, far above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    {rstn, wr, rd, halt_req, ack_req, panel, op_stop, pos_hit} = '0;
    {ovt, soft_p, soft_n, ref_sw, ref_w, malf, cat1, gear, move, dneg} = '0;
    still = 1'b1;
    addr = '0;
    wdata = '0;
    cspd = 32'h0000_03e8;
    // Modest rates, so braking trips on overvoltage only on purpose
    ndec = 32'h0000_0064;
    gacc = 32'h0000_00c8;
    cyc(3);
    rstn <= 1'b1;
    cyc(4);
    t_regs();
    t_halt_pin();
    t_level_ack();
    t_malf(1'b1);
    t_malf(1'b0);
    t_overvolt();
    t_invert();
    wr_reg(OFS_MASK, 32'h0000_0001);
    wr_reg(OFS_DECEL, 32'h0000_0100);
    t_ramp(1'b0, 32'h0000_02e8);
    t_ramp(1'b1, 32'h0000_0320);
    end_of_test();
  end
endmodule : tb_emergency_halt_direction_control
`default_nettype wire
